// *** eelpi_pkg.sv ***
/*
  Package for the EEPROM lock, program and interrupt front end: register
  offsets, field positions, reset values, status codes and sizes.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package eelpi_pkg;
  localparam int          BLOCKS_C     = 4;
  localparam int          BLK_W_C      = 2;
  localparam int          WORDS_C      = 16;
  localparam int          WADDR_W_C    = 4;
  localparam int          PROG_CYC_C   = 8;
  localparam logic [31:0] NO_PW_C      = 32'hFFFFFFFF;

  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_BLOCK    = 8'h04;
  localparam logic [7:0] OFF_PW0      = 8'h08;
  localparam logic [7:0] OFF_PW1      = 8'h0C;
  localparam logic [7:0] OFF_PW2      = 8'h10;
  localparam logic [7:0] OFF_CMD      = 8'h14;
  localparam logic [7:0] OFF_RESULT   = 8'h18;
  localparam logic [7:0] OFF_ADDR     = 8'h1C;
  localparam logic [7:0] OFF_DATA     = 8'h20;
  localparam logic [7:0] OFF_COUNT    = 8'h24;
  localparam logic [7:0] OFF_INT_EN   = 8'h28;
  localparam logic [7:0] OFF_INT_RAW  = 8'h2C;
  localparam logic [7:0] OFF_INT_MSK  = 8'h30;
  localparam logic [7:0] OFF_INT_CLR  = 8'h34;
  localparam logic [7:0] OFF_FLASH_IM = 8'h38;
  localparam logic [7:0] OFF_INIT     = 8'h3C;

  localparam int BIT_INT_PROGRAM = 0;
  localparam int BIT_PROT_LO     = 0;

  // Command codes written to the command register.
  localparam logic [2:0] CMD_UNLOCK  = 3'h1;
  localparam logic [2:0] CMD_LOCK    = 3'h2;
  localparam logic [2:0] CMD_PW_SET  = 3'h3;
  localparam logic [2:0] CMD_PROT    = 3'h4;
  localparam logic [2:0] CMD_PROG    = 3'h5;
  localparam logic [2:0] CMD_PROG_NB = 3'h6;
  localparam logic [2:0] CMD_INIT    = 3'h7;

  localparam logic [5:0] RC_INVPL  = 6'h01;
  localparam logic [5:0] RC_WRBUSY = 6'h02;
  localparam logic [5:0] RC_NOPERM = 6'h04;
  localparam logic [5:0] RC_WKCOPY = 6'h08;
  localparam logic [5:0] RC_WKERAS = 6'h10;
  localparam logic [5:0] RC_WORK   = 6'h20;

  localparam logic [1:0] INIT_OK    = 2'h0;
  localparam logic [1:0] INIT_RETRY = 2'h1;
  localparam logic [1:0] INIT_ERROR = 2'h2;

  localparam logic [1:0] PROT_RW_LRO = 2'h0;
  localparam logic [1:0] PROT_NA_LNA = 2'h1;
  localparam logic [1:0] PROT_RO_LNA = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_PROG} eelpi_state_t;
endpackage : eelpi_pkg

// *** eelpi_top.sv ***
/*
  EEPROM lock, program and interrupt front end with an APB register slave.
  Holds passwords, lock and protection state, a small word store, a
  program sequencer, power-fail recovery check and the completion interrupt.
  Assumes pclk at 125 MHz, the power-fail and fatal power-fail flags from the array as pins, and an
  external combiner using flash_irq together with the flash sources.
*/
`timescale 1ns/10ps
module eelpi_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_fail_pin,
  input  wire logic        power_fail_fatal_pin,
  output logic             flash_irq
);
  import eelpi_pkg::*;

  logic [31:0]          pw_reg [BLOCKS_C][3];
  logic [1:0]           pwcnt_reg [BLOCKS_C];
  logic [1:0]           prot_reg [BLOCKS_C];
  logic                 locked_reg [BLOCKS_C];
  logic [31:0]          mem_reg [WORDS_C];
  logic [BLK_W_C-1:0]   blk_reg;
  logic [31:0]          pwin_reg [3];
  logic [31:0]          addr_reg;
  logic [31:0]          data_reg;
  logic [31:0]          count_reg;
  logic [31:0]          result_reg;
  logic                 int_en_reg;
  logic                 int_raw_reg;
  logic                 flash_im_reg;
  logic [1:0]           init_reg;
  logic                 init_done_reg;
  logic                 enable_reg;
  logic                 irq_reg;
  logic                 ready_reg;
  logic [31:0]          rdata_reg;
  logic                 pf_s1_reg, pf_s2_reg, pff_s1_reg, pff_s2_reg;
  eelpi_state_t         state_reg;
  logic [7:0]           cyc_reg;
  logic                 busy_done;

  wire        acc_set   = psel && !penable;
  wire        wr_take   = psel && penable && pwrite && ready_reg;
  wire        rd_take   = psel && penable && !pwrite && ready_reg;
  wire [7:0]  off       = paddr[7:0];
  wire        mapped    = (off <= OFF_INIT) && (off[1:0] == 2'b00);
  wire [2:0]  cmd       = pwdata[2:0];
  wire        cmd_go    = wr_take && (off == OFF_CMD);
  wire [1:0]  cnt_in    = pwdata[5:4];
  wire        busy      = (state_reg == ST_PROG);
  wire [WADDR_W_C-1:0] widx = addr_reg[WADDR_W_C+1:2];
  wire [BLK_W_C-1:0]   wblk = addr_reg[WADDR_W_C+1:WADDR_W_C+2-BLK_W_C];

  // Password match across 1..3 words; all-ones words never match.
  wire w0_ok = (pwin_reg[0] == pw_reg[blk_reg][0]) && (pwin_reg[0] != NO_PW_C);
  wire w1_ok = (pwin_reg[1] == pw_reg[blk_reg][1]) || (cnt_in < 2'd2);
  wire w2_ok = (pwin_reg[2] == pw_reg[blk_reg][2]) || (cnt_in < 2'd3);
  wire pw_match = (cnt_in != 2'd0) && (cnt_in == pwcnt_reg[blk_reg])
                  && w0_ok && w1_ok && w2_ok;
  wire pw_bad = (pwin_reg[0] == NO_PW_C) || (cnt_in == 2'd0) ||
                ((cnt_in > 2'd1) && (pwin_reg[1] == NO_PW_C)) ||
                ((cnt_in > 2'd2) && (pwin_reg[2] == NO_PW_C));

  // Effective write permission: block 0 gates all, protection ORed.
  wire blk0_open  = !locked_reg[0];
  wire own_locked = locked_reg[wblk];
  // Effective protection is the OR of block 0's and the target's settings.
  wire no_pw      = (pwcnt_reg[wblk] == 2'd0);
  wire any_ro     = (prot_reg[wblk] == PROT_RO_LNA) || (prot_reg[0] == PROT_RO_LNA);
  wire any_na     = (prot_reg[wblk] == PROT_NA_LNA) || (prot_reg[0] == PROT_NA_LNA);
  // A no-access level opens only through a password, so an unprotected block stays shut.
  wire may_write  = ((wblk == '0) || blk0_open) && !(own_locked && !no_pw)
                    && !any_ro && !(any_na && no_pw);
  // A non-blocking program always moves one word, whatever the count register holds.
  wire        prog_cmd = (cmd == CMD_PROG) || (cmd == CMD_PROG_NB);
  wire [31:0] cnt_eff  = (cmd == CMD_PROG_NB) ? 32'h00000004 : count_reg;
  // The end check uses one spare bit so a huge count cannot wrap back into range.
  wire prm_bad    = (addr_reg[1:0] != 2'b00) || (cnt_eff[1:0] != 2'b00) ||
                    (({1'b0, addr_reg[31:2]} + {1'b0, cnt_eff[31:2]}) > 31'(WORDS_C));

  // Read mux.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (off)
      OFF_CTRL:     rd_mux = {31'h0, enable_reg};
      OFF_BLOCK:    rd_mux = {{(32-BLK_W_C){1'b0}}, blk_reg};
      OFF_RESULT:   rd_mux = result_reg;
      OFF_ADDR:     rd_mux = addr_reg;
      OFF_DATA:     rd_mux = data_reg;
      OFF_COUNT:    rd_mux = count_reg;
      OFF_INT_EN:   rd_mux = {31'h0, int_en_reg};
      OFF_INT_RAW:  rd_mux = {31'h0, int_raw_reg};
      OFF_INT_MSK:  rd_mux = {31'h0, int_raw_reg & int_en_reg};
      OFF_FLASH_IM: rd_mux = {31'h0, flash_im_reg};
      OFF_INIT:     rd_mux = {29'h0, init_done_reg, init_reg};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  // Synchronise the array's power-fail flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pf_s1_reg, pf_s2_reg, pff_s1_reg, pff_s2_reg} <= 4'h0;
    end else begin
      pf_s1_reg  <= power_fail_pin;
      pf_s2_reg  <= pf_s1_reg;
      pff_s1_reg <= power_fail_fatal_pin;
      pff_s2_reg <= pff_s1_reg;
    end
  end

  // APB handshake: no wait state, answer in the cycle after setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      pslverr   <= 1'b0;
    end else begin
      ready_reg <= acc_set;
      pslverr   <= acc_set && !mapped;
      rdata_reg <= acc_set ? rd_mux : rdata_reg;
    end
  end
  assign prdata = rdata_reg;
  assign pready = ready_reg;

  // Program sequencer: blocking runs count/4 words, non-blocking one word.
  assign busy_done = busy && (cyc_reg == 8'(PROG_CYC_C - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cyc_reg   <= 8'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (cmd_go && prog_cmd && enable_reg
                     && init_done_reg && !prm_bad && may_write && cnt_eff != 32'h0) begin
          state_reg <= ST_PROG;
          cyc_reg   <= 8'h00;
        end
        ST_PROG: begin
          cyc_reg <= busy_done ? 8'h00 : cyc_reg + 8'h01;
          if (busy_done && count_reg <= 32'h4) state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Interrupt: set wins over clear, gated by enable and flash mask.
  wire int_clr = wr_take && (off == OFF_INT_CLR) && pwdata[BIT_INT_PROGRAM];
  wire prog_end = busy_done && count_reg <= 32'h4;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_raw_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      int_raw_reg <= prog_end ? 1'b1 : (int_clr ? 1'b0 : int_raw_reg);
      irq_reg     <= int_raw_reg && int_en_reg && flash_im_reg;
    end
  end
  assign flash_irq = irq_reg;

  // Register and command writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < BLOCKS_C; b++) begin
        for (int k = 0; k < 3; k++) pw_reg[b][k] <= NO_PW_C;
        pwcnt_reg[b]  <= 2'd0;
        prot_reg[b]   <= PROT_RW_LRO;
        locked_reg[b] <= 1'b0;
      end
      for (int i = 0; i < WORDS_C; i++) mem_reg[i] <= 32'h00000000;
      for (int k = 0; k < 3; k++) pwin_reg[k] <= NO_PW_C;
      blk_reg       <= '0;
      addr_reg      <= 32'h00000000;
      data_reg      <= 32'h00000000;
      count_reg     <= 32'h00000000;
      result_reg    <= 32'h00000000;
      int_en_reg    <= 1'b0;
      flash_im_reg  <= 1'b0;
      enable_reg    <= 1'b0;
      init_reg      <= INIT_OK;
      init_done_reg <= 1'b0;
    end else begin
      // The working code set at start stands until the last word, so a busy refusal
      // stays visible to software instead of being overwritten in the next cycle.
      if (busy) begin
        if (busy_done) begin
          mem_reg[widx] <= data_reg;
          addr_reg      <= addr_reg + 32'h4;
          count_reg     <= (count_reg > 32'h4) ? count_reg - 32'h4 : 32'h0;
          data_reg      <= mem_reg[widx + 4'h1];
          if (count_reg <= 32'h4) result_reg <= 32'h00000000;
        end
      end
      if (wr_take) begin
        unique case (off)
          OFF_CTRL:     enable_reg <= pwdata[0];
          OFF_BLOCK:    blk_reg <= pwdata[BLK_W_C-1:0];
          OFF_PW0:      pwin_reg[0] <= pwdata;
          OFF_PW1:      pwin_reg[1] <= pwdata;
          OFF_PW2:      pwin_reg[2] <= pwdata;
          OFF_ADDR:     if (!busy) addr_reg <= pwdata;
          OFF_DATA:     if (!busy) data_reg <= pwdata;
          OFF_COUNT:    if (!busy) count_reg <= pwdata;
          OFF_INT_EN:   int_en_reg <= pwdata[BIT_INT_PROGRAM];
          OFF_FLASH_IM: flash_im_reg <= pwdata[BIT_INT_PROGRAM];
          default:      ;
        endcase
      end
      if (cmd_go) begin
        unique case (cmd)
          CMD_UNLOCK: begin
            // Lock state updates in the same edge, ahead of any later access.
            if (pw_match) locked_reg[blk_reg] <= 1'b0;
            result_reg <= {31'h0, pw_match || !locked_reg[blk_reg]};
          end
          CMD_LOCK: begin
            if (pwcnt_reg[blk_reg] != 2'd0) locked_reg[blk_reg] <= 1'b1;
            result_reg <= {31'h0, pwcnt_reg[blk_reg] == 2'd0};
          end
          CMD_PW_SET: begin
            if (pwcnt_reg[blk_reg] != 2'd0) begin
              result_reg <= {26'h0, RC_NOPERM};
            end else if (pw_bad) begin
              result_reg <= {26'h0, RC_INVPL};
            end else begin
              for (int k = 0; k < 3; k++) pw_reg[blk_reg][k] <= pwin_reg[k];
              pwcnt_reg[blk_reg] <= cnt_in;
              result_reg <= 32'h00000000;
            end
          end
          CMD_PROT: begin
            prot_reg[blk_reg] <= pwdata[BIT_PROT_LO+9:BIT_PROT_LO+8];
            result_reg <= 32'h00000000;
          end
          CMD_PROG, CMD_PROG_NB: begin
            if (busy) result_reg <= {26'h0, RC_WRBUSY | RC_WORK};
            else if (prm_bad || cnt_eff == 32'h0 || !enable_reg || !init_done_reg)
              result_reg <= {26'h0, RC_INVPL};
            else if (!may_write) result_reg <= {26'h0, RC_NOPERM};
            else begin
              result_reg <= {26'h0, RC_WORK};
              if (cmd == CMD_PROG_NB) count_reg <= 32'h4;
            end
          end
          CMD_INIT: begin
            // Recovery outcome from the array's flags.
            init_done_reg <= enable_reg;
            init_reg      <= pff_s2_reg ? INIT_ERROR : (pf_s2_reg ? INIT_RETRY : INIT_OK);
          end
          default: ;
        endcase
      end
    end
  end
endmodule : eelpi_top

// *** eelpi_sva.sv ***
/*
  Port checker for the EEPROM lock, program and interrupt front end.
  Assumes the no-wait APB answer and registered interrupt output of eelpi_top.
*/
`timescale 1ns/10ps
module eelpi_sva
  import eelpi_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        power_fail_pin,
  input wire logic        power_fail_fatal_pin,
  input wire logic        flash_irq
);
  logic en_q;
  logic fm_q;
  wire  acc    = psel && penable && pready;
  wire  wr_acc = acc && pwrite;
  // Shadow copies of the two enables, so a masked source can be judged from the pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      fm_q <= 1'b0;
    end else begin
      if (wr_acc && paddr[7:0] == OFF_INT_EN) en_q <= pwdata[0];
      if (wr_acc && paddr[7:0] == OFF_FLASH_IM) fm_q <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_UNMAPPED: assert property (acc && paddr[7:0] >= 8'h40 |-> pslverr)
    else $error("unmapped offset not refused");
  AST_ERR_MAPPED: assert property (acc && paddr[7:0] < 8'h40 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped offset refused");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  AST_IRQ_DISABLED: assert property (!en_q && !$past(en_q) |-> !flash_irq)
    else $error("irq with enable clear");
  AST_IRQ_FLASH_MASK: assert property (!fm_q && !$past(fm_q) |-> !flash_irq)
    else $error("irq with flash mask clear");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> !pready && !pslverr && !flash_irq)
    else $error("outputs active after reset");
  COV_IRQ: cover property ($rose(flash_irq));
  COV_ERR: cover property (pslverr);
  COV_WRITE: cover property (wr_acc && paddr[7:0] == OFF_CMD);
endmodule : eelpi_sva

bind eelpi_top eelpi_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .power_fail_pin(power_fail_pin), .power_fail_fatal_pin(power_fail_fatal_pin),
  .flash_irq(flash_irq)
);

// *** tb.sv ***
/*
  Self-checking bench for eelpi_top: APB master tasks and scenarios.
  Assumes the register map and command codes of eelpi_pkg.
*/
`timescale 1ns/10ps
module tb;
  import eelpi_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pf = 0, pff = 0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, pw0, pw1;
  logic        pready, pslverr, flash_irq, err;
  int          n_errors = 0, compares = 0;
  always #4 pclk = ~pclk;
  eelpi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_fail_pin(pf), .power_fail_fatal_pin(pff), .flash_irq(flash_irq));
  task automatic close_out;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, exp);
  endtask : rdchk
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    for (int k = 0; k < 60; k++) begin
      apb(1'b0, a, 32'h0);
      if ((rd & m) === v) return;
    end
    n_errors++;
    close_out();
  endtask : poll
  function automatic logic [31:0] cmd(input logic [2:0] c, input logic [1:0] cnt);
    return {26'h0, cnt, 1'b0, c};
  endfunction : cmd
  function automatic logic [31:0] init_exp(input logic p, input logic f);
    return {30'h0, f ? INIT_ERROR : (p ? INIT_RETRY : INIT_OK)};
  endfunction : init_exp
  task automatic pwd(input logic [1:0] b, input logic [2:0] c, input logic [1:0] n,
                     input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
    apb(1'b1, OFF_BLOCK, {30'h0, b});
    apb(1'b1, OFF_PW0, w0);
    apb(1'b1, OFF_PW1, w1);
    apb(1'b1, OFF_PW2, w2);
    apb(1'b1, OFF_CMD, cmd(c, n));
  endtask : pwd
  task automatic prog(input logic [7:0] a, input logic [7:0] n, input logic [2:0] c);
    apb(1'b1, OFF_INT_CLR, 32'h1);
    apb(1'b1, OFF_ADDR, {24'h0, a});
    apb(1'b1, OFF_DATA, $urandom);
    apb(1'b1, OFF_COUNT, {24'h0, n});
    apb(1'b1, OFF_CMD, cmd(c, 2'h0));
    if (c == CMD_PROG_NB) rdchk("nb_busy", OFF_RESULT, 32'hFF, {26'h0, RC_WORK});
    if (n > 8'h04) begin
      // A second start while the first still runs must be refused as busy.
      apb(1'b1, OFF_CMD, cmd(c, 2'h0));
      rdchk("wr_busy", OFF_RESULT, 32'h3F, {26'h0, RC_WRBUSY | RC_WORK});
    end
    poll(OFF_RESULT, {26'h0, RC_WORK}, 32'h0);
  endtask : prog
  task automatic irq(input string nm, input logic e);
    repeat (2) @(posedge pclk);
    chk(nm, {31'h0, flash_irq}, {31'h0, e});
  endtask : irq
  initial begin
    rd = $urandom(32'h5BCF);
    pw0 = $urandom >> 1;
    pw1 = $urandom >> 1;
    // Each pass resets with a different power-fail story, the clean one last.
    for (int i = 0; i < 3; i++) begin
      pf <= (i == 1);
      pff <= (i == 0);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      if (i == 0) prog(8'h00, 8'h04, CMD_PROG);
      if (i == 0) chk("no_init", rd & 32'h1, {26'h0, RC_INVPL});
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_CMD, cmd(CMD_INIT, 2'h0));
      poll(OFF_INIT, 32'h4, 32'h4);
      chk("init", rd & 32'h3, init_exp(i == 1, i == 0));
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    rdchk("raw_reset", OFF_INT_RAW, 32'h1, 32'h0);
    apb(1'b1, OFF_INT_EN, 32'h1);
    apb(1'b1, OFF_FLASH_IM, 32'h1);
    pwd(2'h1, CMD_PW_SET, 2'h1, pw1, 32'h0, 32'h0);
    rdchk("pw_set", OFF_RESULT, 32'h3F, 32'h0);
    pwd(2'h1, CMD_PW_SET, 2'h1, pw1, 32'h0, 32'h0);
    rdchk("pw_again", OFF_RESULT, 32'h4, {26'h0, RC_NOPERM});
    pwd(2'h2, CMD_PW_SET, 2'h1, NO_PW_C, 32'h0, 32'h0);
    rdchk("pw_ones", OFF_RESULT, 32'h3F, {26'h0, RC_INVPL});
    pwd(2'h1, CMD_LOCK, 2'h0, 32'h0, 32'h0, 32'h0);
    rdchk("lock", OFF_RESULT, 32'h1, 32'h0);
    prog(8'h10, 8'h04, CMD_PROG);
    chk("locked_prog", rd & 32'h4, {26'h0, RC_NOPERM});
    pwd(2'h1, CMD_UNLOCK, 2'h1, pw1 ^ 32'h1, 32'h0, 32'h0);
    rdchk("bad_pw", OFF_RESULT, 32'h1, 32'h0);
    pwd(2'h1, CMD_UNLOCK, 2'h2, pw1, pw1, 32'h0);
    rdchk("bad_count", OFF_RESULT, 32'h1, 32'h0);
    pwd(2'h1, CMD_UNLOCK, 2'h1, pw1, 32'h0, 32'h0);
    rdchk("unlock", OFF_RESULT, 32'h1, 32'h1);
    prog(8'h18, 8'h08, CMD_PROG);
    chk("prog", rd, 32'h0);
    rdchk("raw", OFF_INT_RAW, 32'h1, 32'h1);
    rdchk("masked", OFF_INT_MSK, 32'h1, 32'h1);
    irq("irq_on", 1'b1);
    apb(1'b1, OFF_FLASH_IM, 32'h0);
    irq("flash_mask", 1'b0);
    apb(1'b1, OFF_INT_CLR, 32'h1);
    rdchk("cleared", OFF_INT_RAW, 32'h1, 32'h0);
    pwd(2'h0, CMD_PW_SET, 2'h3, pw0, pw0 ^ 32'h3, pw0 ^ 32'h5);
    pwd(2'h0, CMD_LOCK, 2'h0, 32'h0, 32'h0, 32'h0);
    prog(8'h20, 8'h04, CMD_PROG);
    chk("blk0_locked", rd & 32'h4, {26'h0, RC_NOPERM});
    pwd(2'h0, CMD_UNLOCK, 2'h3, pw0, pw0 ^ 32'h3, pw0 ^ 32'h5);
    rdchk("unlock0", OFF_RESULT, 32'h1, 32'h1);
    apb(1'b1, OFF_INT_EN, 32'h0);
    apb(1'b1, OFF_FLASH_IM, 32'h1);
    prog(8'h24, 8'h04, CMD_PROG_NB);
    chk("blk0_open", rd, 32'h0);
    rdchk("nb_raw", OFF_INT_RAW, 32'h1, 32'h1);
    rdchk("nb_masked", OFF_INT_MSK, 32'h1, 32'h0);
    irq("irq_disabled", 1'b0);
    apb(1'b1, OFF_INT_EN, 32'h1);
    irq("irq_enabled", 1'b1);
    apb(1'b1, OFF_BLOCK, 32'h3);
    apb(1'b1, OFF_CMD, {22'h0, PROT_RO_LNA, 5'h0, CMD_PROT});
    prog(8'h30, 8'h04, CMD_PROG);
    chk("prot_ro", rd & 32'h4, {26'h0, RC_NOPERM});
    apb(1'b1, OFF_BLOCK, 32'h2);
    apb(1'b1, OFF_CMD, {22'h0, PROT_NA_LNA, 5'h0, CMD_PROT});
    prog(8'h28, 8'h04, CMD_PROG);
    chk("prot_na", rd & 32'h4, {26'h0, RC_NOPERM});
    close_out();
  end
endmodule : tb
